// ==== rtl/eth_chan_map.vh ====
/*
  Constants of the Ethernet channel: CRC, preamble, fault window, receive and transmit
  state codes, DMA acknowledge codes and status field positions.
  Assumes it is included by bare name from the channel's design files.
*/
`ifndef ETH_CHAN_MAP_VH
`define ETH_CHAN_MAP_VH

// CRC-32, reflected form, shifted LSB first
`define ETH_CRC_POLY        32'hedb88320
`define ETH_CRC_INIT        32'hffffffff
`define ETH_CRC_RESIDUE     32'hdebb20e3

// Transmit framing
`define ETH_PREAMBLE_BYTE   8'h55
`define ETH_SFD_BYTE        8'hd5
`define ETH_PREAMBLE_LAST   3'h6
`define ETH_FCS_BYTES_LAST  2'h3

// Receive preamble fault window (1-based bit positions from frame start)
`define ETH_FAULT_FIRST     6'h0e
`define ETH_FAULT_LAST      6'h15
`define ETH_BITPOS_MAX      6'h3f

// Address recognition and collision classing
`define ETH_ADDR_LAST_BYTE  16'h0005
`define ETH_LATE_COL_BYTES  16'h0040

// DMA acknowledge codes
`define ETH_ACK_NONE        2'h0
`define ETH_ACK_FIRST       2'h1
`define ETH_ACK_MID         2'h2
`define ETH_ACK_TAG         2'h3

// Receive status field positions
`define ETH_ST_CRC_ERR      0
`define ETH_ST_NONOCTET     1
`define ETH_ST_LATE_COL     2
`define ETH_ST_SHORT        3

// Receive states
`define ETH_RX_OFF          3'h0
`define ETH_RX_HUNT         3'h1
`define ETH_RX_DATA         3'h2
`define ETH_RX_END          3'h3
`define ETH_RX_DROP         3'h4

// Transmit states
`define ETH_TX_IDLE         3'h0
`define ETH_TX_PRE          3'h1
`define ETH_TX_DATA         3'h2
`define ETH_TX_TAIL         3'h3
`define ETH_TX_FCS          3'h4
`define ETH_TX_END          3'h5
`define ETH_TX_HALT         3'h6

`endif

// ==== rtl/eth_pin_sync.v ====
/*
  Two-flip-flop synchroniser bank for pins arriving from outside the clk_in domain.
  Assumes a reset already released synchronously to clk_in.
*/
`timescale 1ns/1ns
module eth_pin_sync #(
  parameter WIDTH = 14
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire             ce_in,
  input  wire [WIDTH-1:0] d_in,
  output wire [WIDTH-1:0] q_out
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta_r;
      reg sync_r;
      always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else if (ce_in) begin
          meta_r <= d_in[g];
          sync_r <= meta_r;
        end
      end
      assign q_out[g] = sync_r;
    end
  endgenerate

endmodule // eth_pin_sync

// ==== rtl/eth_rx_cam_channel.v ====
/*
  Ethernet channel: transmit framing with padding and graceful halt, receive hunt and
  preamble checks, address gating, descriptor filling, CAM start/reject/tag and DMA codes.
  Assumes link clocks and pins are asynchronous and are oversampled by clk_in.
*/
`timescale 1ns/1ns
`include "eth_chan_map.vh"
module eth_rx_cam_channel #(
  parameter QDEPTH_LOG2 = 2
) (
  input  wire        clk_in,
  input  wire        nrst_in,
  input  wire        ce_in,
  input  wire        rx_clk_in,
  input  wire        rxd_in,
  input  wire        receive_enable_in,
  input  wire        collision_in,
  input  wire        receive_reject_in,
  input  wire [7:0]  tag_input_lines_in,
  input  wire [7:0]  port_b_dir_in,
  input  wire [7:0]  port_b_data_latch_in,
  input  wire        rx_enable_in,
  input  wire [7:0]  sync_pattern_in,
  input  wire [5:0]  sync_compare_delay_in,
  input  wire [47:0] station_addr_in,
  input  wire        promiscuous_in,
  input  wire        tag_append_enable_in,
  input  wire [15:0] max_rx_buffer_length_in,
  input  wire        rx_bd_empty_in,
  input  wire        rx_bd_irq_en_in,
  input  wire        rx_frame_irq_mask_in,
  input  wire        dma_ready_in,
  output reg         dma_wr_out,
  output reg  [31:0] dma_data_out,
  output reg  [3:0]  dma_be_out,
  output reg  [1:0]  dma_ack_code_out,
  output reg         rx_bd_close_out,
  output reg         rx_bd_last_out,
  output reg  [15:0] rx_bd_len_out,
  output reg  [3:0]  rx_bd_status_out,
  output reg         rx_bd_rewind_out,
  output reg         rx_buf_irq_out,
  output reg         rx_frame_irq_out,
  output reg         receive_start_pulse_out,
  input  wire        tx_clk_in,
  input  wire        tx_bd_ready_in,
  input  wire [15:0] tx_bd_len_in,
  input  wire        tx_bd_pad_in,
  input  wire        tx_bd_last_in,
  input  wire        tx_bd_irq_en_in,
  input  wire [7:0]  tx_byte_in,
  input  wire [15:0] min_frame_length_in,
  input  wire [7:0]  pad_char_in,
  input  wire        graceful_tx_halt_cmd_in,
  input  wire        restart_tx_cmd_in,
  output reg         txd_out,
  output reg         tx_enable_out,
  output reg         tx_byte_take_out,
  output reg         tx_bd_done_out,
  output reg         tx_irq_out,
  output wire        tx_halted_out
);

  ////////////////////////////////////////////////////////////////////////////////////////
  // Reset release, pin synchronisers, link clock edges
  reg  [1:0]  rst_sync_r;
  wire        rst_n = rst_sync_r[1];
  wire [13:0] syn;
  reg         rxc_d_r;
  reg         txc_d_r;

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  eth_pin_sync #(.WIDTH(14)) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n),
    .ce_in    (ce_in),
    .d_in     ({tag_input_lines_in, tx_clk_in, receive_reject_in, collision_in,
                receive_enable_in, rxd_in, rx_clk_in}),
    .q_out    (syn)
  );

  wire       rxd_s  = syn[1];
  wire       ren_s  = syn[2];
  wire       col_s  = syn[3];
  wire       rjct_s = syn[4];
  wire [7:0] tag_s  = syn[13:6];
  wire       rxe    = syn[0] & ~rxc_d_r;
  wire       txe    = syn[5] & ~txc_d_r;
  wire       cs     = ren_s | col_s;
  wire [7:0] tag_val = (port_b_dir_in & port_b_data_latch_in) | (~port_b_dir_in & tag_s);

  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rxc_d_r <= 1'b0;
      txc_d_r <= 1'b0;
    end else if (ce_in) begin
      rxc_d_r <= syn[0];
      txc_d_r <= syn[5];
    end
  end

  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0]  d;
    integer      i;
    reg   [31:0] x;
    begin
      x = c;
      for (i = 0; i < 8; i = i + 1) begin
        x = (x >> 1) ^ ((x[0] ^ d[i]) ? `ETH_CRC_POLY : 32'h00000000);
      end
      crc_byte = x;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////
  // Receive framing
  reg  [2:0]  rs_r;
  reg  [7:0]  sh_r;
  reg         prev_r;
  reg  [5:0]  bitpos_r;
  reg  [2:0]  bit_r;
  reg  [15:0] fbytes_r;
  reg  [31:0] rcrc_r;
  reg  [31:0] wacc_r;
  reg         nomatch_r;
  reg         nobc_r;
  reg         allow_r;
  reg         late_r;
  reg         first_word_r;
  reg         first_bit_r;
  reg         push_r;
  reg  [38:0] push_d_r;
  reg         flush_r;
  reg  [15:0] fin_len_r;
  reg  [3:0]  fin_stat_r;
  reg         busy_r;

  wire [5:0]  hpos   = (bitpos_r == `ETH_BITPOS_MAX) ? bitpos_r : bitpos_r + 6'h01;
  wire [7:0]  rbyte  = {rxd_s, sh_r[7:1]};
  wire [7:0]  st_byte = station_addr_in[{fbytes_r[2:0], 3'b000} +: 8];
  wire [3:0]  tail_be = (fbytes_r[1:0] == 2'h1) ? 4'h1 : (fbytes_r[1:0] == 2'h2) ? 4'h3 : 4'h7;

  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rs_r <= `ETH_RX_OFF;
      sh_r <= 8'h00;
      prev_r <= 1'b0;
      bitpos_r <= 6'h00;
      bit_r <= 3'h0;
      fbytes_r <= 16'h0000;
      rcrc_r <= `ETH_CRC_INIT;
      wacc_r <= 32'h00000000;
      nomatch_r <= 1'b0;
      nobc_r <= 1'b0;
      allow_r <= 1'b0;
      late_r <= 1'b0;
      first_word_r <= 1'b0;
      first_bit_r <= 1'b0;
      push_r <= 1'b0;
      push_d_r <= 39'h0000000000;
      flush_r <= 1'b0;
      fin_len_r <= 16'h0000;
      fin_stat_r <= 4'h0;
      receive_start_pulse_out <= 1'b0;
    end else if (ce_in) begin
      push_r <= 1'b0;
      flush_r <= 1'b0;
      if (rs_r != `ETH_RX_DATA) begin
        receive_start_pulse_out <= 1'b0;
      end
      case (rs_r)
        `ETH_RX_OFF: begin
          if (rx_enable_in && ren_s && !col_s) begin
            rs_r <= `ETH_RX_HUNT;
            bitpos_r <= 6'h00;
            sh_r <= 8'h00;
            prev_r <= 1'b0;
          end
        end
        `ETH_RX_HUNT: begin
          if (!cs) begin
            rs_r <= `ETH_RX_OFF;
          end else if (rxe) begin
            bitpos_r <= (bitpos_r == `ETH_BITPOS_MAX) ? bitpos_r : hpos;
            sh_r <= rbyte;
            prev_r <= rxd_s;
            if (bitpos_r != 6'h00 && rxd_s == prev_r &&
                hpos >= `ETH_FAULT_FIRST && hpos <= `ETH_FAULT_LAST) begin
              rs_r <= `ETH_RX_DROP;
            end else if (hpos > `ETH_FAULT_LAST && !rxd_s && !prev_r) begin
              rs_r <= `ETH_RX_DROP;
            end else if (hpos >= sync_compare_delay_in && rbyte == sync_pattern_in) begin
              rs_r <= `ETH_RX_DATA;
              bit_r <= 3'h0;
              fbytes_r <= 16'h0000;
              rcrc_r <= `ETH_CRC_INIT;
              nomatch_r <= 1'b0;
              nobc_r <= 1'b0;
              allow_r <= 1'b0;
              late_r <= 1'b0;
              first_word_r <= 1'b1;
              first_bit_r <= 1'b1;
            end
          end
        end
        `ETH_RX_DATA: begin
          if (rjct_s || busy_r) begin
            rs_r <= `ETH_RX_DROP;
            flush_r <= 1'b1;
            allow_r <= 1'b0;
          end else if (col_s && fbytes_r < `ETH_LATE_COL_BYTES) begin
            rs_r <= `ETH_RX_DROP;
            flush_r <= 1'b1;
            allow_r <= 1'b0;
          end else if (!cs) begin
            rs_r <= `ETH_RX_END;
          end else if (rxe) begin
            late_r <= late_r | col_s;
            sh_r <= rbyte;
            bit_r <= bit_r + 3'h1;
            receive_start_pulse_out <= first_bit_r;
            first_bit_r <= 1'b0;
            if (bit_r == 3'h7) begin
              rcrc_r <= crc_byte(rcrc_r, rbyte);
              fbytes_r <= fbytes_r + 16'h0001;
              wacc_r[{fbytes_r[1:0], 3'b000} +: 8] <= rbyte;
              if (fbytes_r[1:0] == 2'h3) begin
                push_r <= 1'b1;
                push_d_r <= {1'b0, first_word_r ? `ETH_ACK_FIRST : `ETH_ACK_MID, 4'hf,
                             rbyte, wacc_r[23:0]};
                first_word_r <= 1'b0;
              end
              if (fbytes_r <= `ETH_ADDR_LAST_BYTE) begin
                nomatch_r <= nomatch_r | (rbyte != st_byte);
                nobc_r <= nobc_r | (rbyte != 8'hff);
                if (fbytes_r == `ETH_ADDR_LAST_BYTE) begin
                  if (promiscuous_in || !(nomatch_r | (rbyte != st_byte)) ||
                      !(nobc_r | (rbyte != 8'hff))) begin
                    allow_r <= 1'b1;
                  end else begin
                    rs_r <= `ETH_RX_DROP;
                  end
                end
              end
            end
          end
        end
        `ETH_RX_END: begin
          if (!allow_r) begin
            rs_r <= `ETH_RX_OFF;
            flush_r <= 1'b1;
          end else begin
            rs_r <= `ETH_RX_OFF;
            push_r <= 1'b1;
            fin_len_r <= fbytes_r;
            fin_stat_r[`ETH_ST_CRC_ERR] <= (rcrc_r != `ETH_CRC_RESIDUE);
            fin_stat_r[`ETH_ST_NONOCTET] <= (bit_r != 3'h0);
            fin_stat_r[`ETH_ST_LATE_COL] <= late_r;
            fin_stat_r[`ETH_ST_SHORT] <= (fbytes_r < min_frame_length_in);
            if (fbytes_r[1:0] != 2'h0) begin
              push_d_r <= {1'b1, `ETH_ACK_NONE, {tag_append_enable_in, 3'b000} | tail_be,
                           tag_append_enable_in ? tag_val : 8'h00, wacc_r[23:0]};
            end else if (tag_append_enable_in) begin
              push_d_r <= {1'b1, `ETH_ACK_TAG, 4'h8, tag_val, 24'h000000};
            end else begin
              push_d_r <= {1'b1, `ETH_ACK_NONE, 4'h0, 32'h00000000};
            end
          end
        end
        `ETH_RX_DROP: begin
          if (!cs) begin
            rs_r <= `ETH_RX_OFF;
          end
        end
        default: begin
          rs_r <= `ETH_RX_OFF;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Word queue, DMA writer, receive descriptors
  localparam QD = 1 << QDEPTH_LOG2;
  reg  [38:0]            wq_r [0:QD-1];
  reg  [QDEPTH_LOG2-1:0] wp_r;
  reg  [QDEPTH_LOG2-1:0] rp_r;
  reg  [QDEPTH_LOG2:0]   cnt_r;
  reg                    need_bd_r;
  reg  [15:0]            bufcnt_r;
  wire [38:0]            head = wq_r[rp_r];
  wire                   can_go = !dma_wr_out && cnt_r != 0 && allow_r && !need_bd_r && !busy_r;
  wire                   pop = (dma_wr_out && dma_ready_in) || (can_go && head[35:32] == 4'h0);
  wire [15:0]            buf_next = bufcnt_r + 16'h0004;

  always @(posedge clk_in) begin
    if (ce_in && push_r) begin
      wq_r[wp_r] <= push_d_r;
    end
  end

  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= {QDEPTH_LOG2{1'b0}};
      rp_r <= {QDEPTH_LOG2{1'b0}};
      cnt_r <= {(QDEPTH_LOG2+1){1'b0}};
      need_bd_r <= 1'b1;
      bufcnt_r <= 16'h0000;
      busy_r <= 1'b0;
      dma_wr_out <= 1'b0;
      dma_data_out <= 32'h00000000;
      dma_be_out <= 4'h0;
      dma_ack_code_out <= `ETH_ACK_NONE;
      rx_bd_close_out <= 1'b0;
      rx_bd_last_out <= 1'b0;
      rx_bd_len_out <= 16'h0000;
      rx_bd_status_out <= 4'h0;
      rx_bd_rewind_out <= 1'b0;
      rx_buf_irq_out <= 1'b0;
      rx_frame_irq_out <= 1'b0;
    end else if (ce_in) begin
      rx_bd_close_out <= 1'b0;
      rx_bd_rewind_out <= 1'b0;
      rx_buf_irq_out <= 1'b0;
      rx_frame_irq_out <= 1'b0;
      if (flush_r) begin
        wp_r <= {QDEPTH_LOG2{1'b0}};
        rp_r <= {QDEPTH_LOG2{1'b0}};
        cnt_r <= {(QDEPTH_LOG2+1){1'b0}};
        need_bd_r <= 1'b1;
        bufcnt_r <= 16'h0000;
        busy_r <= 1'b0;
        dma_wr_out <= 1'b0;
        dma_ack_code_out <= `ETH_ACK_NONE;
        rx_bd_rewind_out <= 1'b1;
      end else begin
        wp_r <= wp_r + {{(QDEPTH_LOG2-1){1'b0}}, push_r};
        cnt_r <= cnt_r + {{QDEPTH_LOG2{1'b0}}, push_r} - {{QDEPTH_LOG2{1'b0}}, pop};
        if (!dma_wr_out && cnt_r != 0 && allow_r && need_bd_r && !busy_r) begin
          if (rx_bd_empty_in) begin
            need_bd_r <= 1'b0;
          end else begin
            busy_r <= 1'b1;
          end
        end else if (can_go && head[35:32] != 4'h0) begin
          dma_wr_out <= 1'b1;
          dma_data_out <= head[31:0];
          dma_be_out <= head[35:32];
          dma_ack_code_out <= head[37:36];
        end
        if (pop) begin
          rp_r <= rp_r + {{(QDEPTH_LOG2-1){1'b0}}, 1'b1};
          dma_wr_out <= 1'b0;
          dma_ack_code_out <= `ETH_ACK_NONE;
          if (head[38]) begin
            rx_bd_close_out <= 1'b1;
            rx_bd_last_out <= 1'b1;
            rx_bd_len_out <= fin_len_r;
            rx_bd_status_out <= fin_stat_r;
            rx_buf_irq_out <= rx_bd_irq_en_in;
            rx_frame_irq_out <= rx_frame_irq_mask_in;
            need_bd_r <= 1'b1;
            bufcnt_r <= 16'h0000;
          end else if (buf_next >= max_rx_buffer_length_in) begin
            rx_bd_close_out <= 1'b1;
            rx_bd_last_out <= 1'b0;
            rx_bd_len_out <= buf_next;
            rx_bd_status_out <= 4'h0;
            rx_buf_irq_out <= rx_bd_irq_en_in;
            need_bd_r <= 1'b1;
            bufcnt_r <= 16'h0000;
          end else begin
            bufcnt_r <= buf_next;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Transmit framing
  reg  [2:0]  ts_r;
  reg  [7:0]  tsh_r;
  reg  [2:0]  tbit_r;
  reg  [2:0]  pcnt_r;
  reg  [15:0] flen_r;
  reg  [15:0] bcnt_r;
  reg  [31:0] tcrc_r;
  reg  [31:0] fcs_r;
  reg  [1:0]  fcnt_r;
  reg         stop_r;

  assign tx_halted_out = (ts_r == `ETH_TX_HALT);

  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ts_r <= `ETH_TX_IDLE;
      tsh_r <= 8'h00;
      tbit_r <= 3'h0;
      pcnt_r <= 3'h0;
      flen_r <= 16'h0000;
      bcnt_r <= 16'h0000;
      tcrc_r <= `ETH_CRC_INIT;
      fcs_r <= 32'h00000000;
      fcnt_r <= 2'h0;
      stop_r <= 1'b0;
      txd_out <= 1'b0;
      tx_enable_out <= 1'b0;
      tx_byte_take_out <= 1'b0;
      tx_bd_done_out <= 1'b0;
      tx_irq_out <= 1'b0;
    end else if (ce_in) begin
      tx_byte_take_out <= 1'b0;
      tx_bd_done_out <= 1'b0;
      tx_irq_out <= 1'b0;
      if (graceful_tx_halt_cmd_in) begin
        stop_r <= 1'b1;
      end else if (restart_tx_cmd_in) begin
        stop_r <= 1'b0;
      end
      case (ts_r)
        `ETH_TX_HALT: begin
          if (restart_tx_cmd_in && !graceful_tx_halt_cmd_in) begin
            ts_r <= `ETH_TX_IDLE;
          end
        end
        `ETH_TX_IDLE: begin
          if (stop_r) begin
            ts_r <= `ETH_TX_HALT;
          end else if (txe && tx_bd_ready_in && !cs) begin
            ts_r <= `ETH_TX_PRE;
            tx_enable_out <= 1'b1;
            tsh_r <= `ETH_PREAMBLE_BYTE;
            tbit_r <= 3'h0;
            pcnt_r <= 3'h0;
            tcrc_r <= `ETH_CRC_INIT;
            flen_r <= 16'h0000;
            bcnt_r <= 16'h0000;
          end
        end
        default: begin
          if (col_s || (txe && ts_r == `ETH_TX_END)) begin
            ts_r <= `ETH_TX_IDLE;
            tx_enable_out <= 1'b0;
            txd_out <= 1'b0;
          end else if (txe) begin
            txd_out <= tsh_r[0];
            tsh_r <= tsh_r >> 1;
            tbit_r <= tbit_r + 3'h1;
            if (tbit_r == 3'h7) begin
              if (ts_r == `ETH_TX_PRE && pcnt_r != 3'h7) begin
                pcnt_r <= pcnt_r + 3'h1;
                tsh_r <= (pcnt_r == `ETH_PREAMBLE_LAST) ? `ETH_SFD_BYTE : `ETH_PREAMBLE_BYTE;
              end else if (ts_r == `ETH_TX_PRE || ts_r == `ETH_TX_DATA) begin
                ts_r <= `ETH_TX_DATA;
                tsh_r <= tx_byte_in;
                tx_byte_take_out <= 1'b1;
                tcrc_r <= crc_byte(tcrc_r, tx_byte_in);
                flen_r <= flen_r + 16'h0001;
                if (bcnt_r + 16'h0001 >= tx_bd_len_in) begin
                  tx_bd_done_out <= 1'b1;
                  tx_irq_out <= tx_bd_irq_en_in;
                  bcnt_r <= 16'h0000;
                  if (tx_bd_last_in) begin
                    ts_r <= `ETH_TX_TAIL;
                  end
                end else begin
                  bcnt_r <= bcnt_r + 16'h0001;
                end
              end else if (ts_r == `ETH_TX_TAIL) begin
                if (tx_bd_pad_in && flen_r + 16'h0004 < min_frame_length_in) begin
                  tsh_r <= pad_char_in;
                  tcrc_r <= crc_byte(tcrc_r, pad_char_in);
                  flen_r <= flen_r + 16'h0001;
                end else begin
                  tsh_r <= ~tcrc_r[7:0];
                  fcs_r <= ~tcrc_r >> 8;
                  fcnt_r <= 2'h0;
                  ts_r <= `ETH_TX_FCS;
                end
              end else if (fcnt_r == `ETH_FCS_BYTES_LAST) begin
                ts_r <= `ETH_TX_END;
              end else begin
                fcnt_r <= fcnt_r + 2'h1;
                tsh_r <= fcs_r[7:0];
                fcs_r <= fcs_r >> 8;
              end
            end
          end
        end
      endcase
    end
  end

endmodule // eth_rx_cam_channel

// ==== dv/eth_chan_asserts.sv ====
/* Port assertions for the channel's DMA codes, CAM start and reject, and carrier deferral.
   Assumes it is bound to eth_rx_cam_channel and sees its ports only. */
`timescale 1ns/1ns
module eth_chan_asserts (
  input wire        clk_in,
  input wire        nrst_in,
  input wire        receive_enable_in,
  input wire        receive_reject_in,
  input wire        dma_ready_in,
  input wire        dma_wr_out,
  input wire [31:0] dma_data_out,
  input wire [3:0]  dma_be_out,
  input wire [1:0]  dma_ack_code_out,
  input wire        rx_bd_close_out,
  input wire        rx_bd_last_out,
  input wire        rx_frame_irq_out,
  input wire        receive_start_pulse_out,
  input wire        tx_enable_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_ack_with_wr: assert property (dma_ack_code_out != 2'h0 |-> dma_wr_out)
    else $error("ack code outside a write");
  a_ack_held: assert property (dma_wr_out && !dma_ready_in |=> $stable(dma_ack_code_out) && $stable(dma_data_out))
    else $error("write changed while waiting");
  a_tag_lane: assert property (dma_ack_code_out == 2'h3 |-> dma_be_out == 4'h8)
    else $error("tag write not in lane 3");
  a_start_one_bit: assert property ($rose(receive_start_pulse_out) |=> receive_start_pulse_out [*8] ##[1:20] !receive_start_pulse_out)
    else $error("start pulse not one bit time");
  a_reject_stops: assert property (receive_reject_in [*6] |-> !dma_wr_out)
    else $error("write during reject");
  a_frame_irq: assert property (rx_frame_irq_out |-> rx_bd_close_out && rx_bd_last_out)
    else $error("frame interrupt without last close");
  a_defer_carrier: assert property (receive_enable_in [*6] |-> !$rose(tx_enable_out))
    else $error("transmit started on carrier");
  a_close_after_wr: assert property (rx_bd_close_out |-> $past(dma_wr_out && dma_ready_in))
    else $error("close without finished write");
endmodule // eth_chan_asserts
bind eth_rx_cam_channel eth_chan_asserts u_chk (.*);

// ==== dv/eth_phy_model.sv ====
/* Receive side of the serial transceiver: clock, data and enable for one frame.
   Assumes the bench fills fr and calls send; clock stands still between frames. */
`timescale 1ns/1ns
module eth_phy_model (
  output logic rx_clk_out,
  output logic rxd_out,
  output logic ren_out
);
  logic [7:0] fr [0:127];
  initial begin
    rx_clk_out = 0;
    rxd_out = 0;
    ren_out = 0;
  end
  // Preamble and delimiter, then frame bytes
  task automatic send(input int n);
    ren_out = 1;
    for (int i = -8; i < n; i++)
      for (int b = 0; b < 8; b++) begin
        rxd_out = (i < 0) ? (!b[0] || (i == -1 && b == 7)) : fr[i][b];
        #80 rx_clk_out = 1;
        #80 rx_clk_out = 0;
      end
    ren_out = 0;
    rxd_out = ~rxd_out;
  endtask
endmodule // eth_phy_model

// ==== dv/eth_rx_cam_channel_tb_top.sv ====
/* Bench: frames with tag, odd tail and reject, plus transmit halt and restart.
   Assumes the design, checker and transceiver model are compiled first. */
`timescale 1ns/1ns
module eth_rx_cam_channel_tb_top;
  logic        clk_in = 0, nrst_in = 0, dma_ready_in = 0, receive_reject_in = 0, tx_clk_in = 0, on = 1;
  logic        graceful_tx_halt_cmd_in = 0, restart_tx_cmd_in = 0;
  logic [7:0]  tag_input_lines_in = 0, port_b_dir_in = 8'hf0, port_b_data_latch_in = 8'h3c, tx_byte_in = 0;
  logic [15:0] mx = 16'h0100, mn = 16'h0040, last_len;
  logic [3:0]  last_st;
  logic [47:0] station_addr_in = 0;
  logic [37:0] q [$];
  wire         rxc, rxd, ren, dma_wr_out, rx_bd_close_out, rx_bd_last_out, rx_bd_rewind_out, tx_enable_out;
  wire         tx_halted_out;
  wire  [31:0] dma_data_out;
  wire  [3:0]  dma_be_out;
  wire  [1:0]  dma_ack_code_out;
  wire  [15:0] rx_bd_len_out;
  wire  [3:0]  rx_bd_status_out;
  int          n_mismatch = 0, checks = 0, frames = 0, rews = 0, bufs = 0, ten = 0, txlen = 0;
  always #4 clk_in = ~clk_in;
  always #80 tx_clk_in = ~tx_clk_in;
  eth_phy_model u_phy (.rx_clk_out(rxc), .rxd_out(rxd), .ren_out(ren));
  eth_rx_cam_channel u_dut (.*, .ce_in(on), .rx_clk_in(rxc), .rxd_in(rxd), .receive_enable_in(ren),
    .collision_in(1'b0), .rx_enable_in(on), .sync_pattern_in(8'hd5), .sync_compare_delay_in(6'h10),
    .promiscuous_in(1'b0), .tag_append_enable_in(on), .max_rx_buffer_length_in(mx), .rx_bd_empty_in(on),
    .rx_bd_irq_en_in(on), .rx_frame_irq_mask_in(on), .tx_bd_ready_in(on), .tx_bd_len_in({12'h001, tx_byte_in[3:0]}),
    .tx_bd_pad_in(on), .tx_bd_last_in(on), .tx_bd_irq_en_in(on), .min_frame_length_in(mn), .pad_char_in(tx_byte_in),
    .rx_buf_irq_out(), .rx_frame_irq_out(), .receive_start_pulse_out(), .txd_out(),
    .tx_byte_take_out(), .tx_bd_done_out(), .tx_irq_out());
  always @(negedge clk_in) begin
    dma_ready_in <= 1'($urandom);
    tx_byte_in <= 8'($urandom);
  end
  always @(posedge clk_in) begin
    if (dma_wr_out && dma_ready_in) q.push_back({dma_ack_code_out, dma_be_out, dma_data_out});
    if (rx_bd_close_out && rx_bd_last_out) begin
      frames++;
      last_len = rx_bd_len_out;
      last_st = rx_bd_status_out;
    end
    if (rx_bd_close_out && !rx_bd_last_out) bufs++;
    if (rx_bd_rewind_out) rews++;
    if (tx_enable_out) ten++;
    else if (ten != 0) begin
      txlen = ten;
      ten = 0;
    end
  end
  function logic [37:0] first_word();
    return {2'h1, 4'hf, u_phy.fr[3], u_phy.fr[2], u_phy.fr[1], u_phy.fr[0]};
  endfunction
  function logic [7:0] tag_exp();
    return (port_b_data_latch_in & port_b_dir_in) | (tag_input_lines_in & ~port_b_dir_in);
  endfunction
  task chk(input string nm, input logic [39:0] s, input logic [39:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic frame(input int n, input bit rj);
    int f;
    f = frames;
    q.delete();
    tag_input_lines_in = 8'($urandom);
    for (int i = 0; i < n; i++) u_phy.fr[i] = (i < 6) ? station_addr_in[8*i+:8] : 8'($urandom);
    fork
      u_phy.send(n);
      if (rj) begin
        repeat (1700) @(negedge clk_in);
        receive_reject_in = 1;
      end
    join
    for (int t = 0; t < 500 && frames == f; t++) @(negedge clk_in);
    receive_reject_in = 0;
  endtask
  task end_of_test();
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #600000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    void'($urandom(6));
    station_addr_in = {16'($urandom), 32'($urandom)};
    repeat (8) @(posedge clk_in);
    @(negedge clk_in) nrst_in = 1;
    repeat (10) @(negedge clk_in);
    frame(64, 0);
    chk("first word", q[0], first_word());
    chk("tag write", {q[$][37:32], q[$][31:24]}, {2'h3, 4'h8, tag_exp()});
    chk("write count", q.size(), 17);
    chk("frame length", last_len, 64);
    chk("frame status", last_st, 4'h1);
    mx = 16'h0040;
    frame(66, 0);
    chk("buffer closes", bufs, 1);
    chk("odd tail code", q[$][37:36], 2'h0);
    chk("odd length", last_len, 66);
    frame(64, 1);
    chk("rewinds", rews, 1);
    chk("frames", frames, 2);
    @(negedge clk_in) graceful_tx_halt_cmd_in = 1;
    @(negedge clk_in) graceful_tx_halt_cmd_in = 0;
    for (int t = 0; t < 15000 && tx_halted_out !== 1'b1; t++) @(negedge clk_in);
    chk("halted", {tx_halted_out, tx_enable_out}, 2'b10);
    chk("tx frame time", txlen, (72 * 8 + 1) * 20);
    @(negedge clk_in) restart_tx_cmd_in = 1;
    @(negedge clk_in) restart_tx_cmd_in = 0;
    repeat (6) @(negedge clk_in);
    chk("resumed", tx_halted_out, 1'b0);
    end_of_test();
  end
endmodule // eth_rx_cam_channel_tb_top
